// ==== logic/nco_defs.vh ====
// Constants for the numerically controlled oscillator block.
// Assumes a byte-wide register port and synchronous clock-source inputs.
//
// Contract
// RQ1 - Twenty-bit accumulator readable and writable as low, high, upper bytes.
// RQ2 - Each selected input clock rising edge adds increment into accumulator.
// RQ3 - Adder carry out is the raw overflow event.
// RQ4 - Input clock chosen from fast oscillator, system clock, logic cell one.
// RQ5 - Clock select codes 00 fast, 01 system, 10 logic cell, 11 reserved.
// RQ6 - Twenty-bit increment held in low, high, upper read/write bytes.
// RQ7 - Software writes upper and high increment bytes before the low byte.
// RQ8 - Enabled: low byte write loads buffer on second input clock edge.
// RQ9 - Disabled: buffer copies increment right after any write; buffer hidden.
// RQ10 - Fixed duty mode toggles output on every overflow.
// RQ11 - Mode bit clear selects fixed duty, set selects pulse mode.
// RQ12 - Pulse mode goes active on edge after overflow, then inactive.
// RQ13 - Three-bit width field sets active length in input clock periods.
// RQ14 - Width is two to the field value periods, 1 up to 128.
// RQ15 - Width longer than overflow period leaves output without toggling.
// RQ16 - Polarity bit inverts the output as the last stage.
// RQ17 - Polarity change with interrupts enabled raises an interrupt.
// RQ18 - Current output level readable as read-only control bit.
// RQ19 - Output routed to peripherals and optionally to a pin.
// RQ20 - Overflow sets flag; request needs module, irq, peripheral, global enables.
// RQ21 - Software clears the interrupt flag in its service routine.
// RQ22 - Reset clears every oscillator register to zero.
// RQ23 - Oscillator keeps running in sleep while its input clock runs.
// RQ24 - Enabled with fast oscillator selected keeps that oscillator on.
// RQ25 - Software avoids writing accumulator while running; reads not atomic.
// RQ26 - Enable bit set runs the oscillator, clear stops it.
// RQ27 - Output level and overflow pass a system-clock stage before status.
`ifndef NCO_DEFS_VH
`define NCO_DEFS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define NCO_ADDR_W 4
`define NCO_OFS_CTRL 4'h0
`define NCO_OFS_CLK 4'h1
`define NCO_OFS_ACCL 4'h2
`define NCO_OFS_ACCH 4'h3
`define NCO_OFS_ACCU 4'h4
`define NCO_OFS_INCL 4'h5
`define NCO_OFS_INCH 4'h6
`define NCO_OFS_INCU 4'h7
`define NCO_OFS_IRQ 4'h8

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define NCO_CTRL_EN 7
`define NCO_CTRL_OUT 5
`define NCO_CTRL_POL 4
`define NCO_CTRL_PFM 0
`define NCO_CLK_PWS_HI 7
`define NCO_CLK_PWS_LO 5
`define NCO_CLK_CKS_HI 1
`define NCO_CLK_CKS_LO 0
`define NCO_IRQ_FLAG 0
`define NCO_IRQ_IE 1
`define NCO_IRQ_PERIPHERAL_IRQ_ENABLE 2
`define NCO_IRQ_GIE 3
`define NCO_IRQ_PIN 4

// ----------------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------------
`define NCO_CKS_FAST 2'h0
`define NCO_CKS_SYS 2'h1
`define NCO_CKS_CELL 2'h2
`define NCO_ACC_W 20
`define NCO_ZERO8 8'h00
`define NCO_ZERO20 20'h00000
`define NCO_LOAD_EDGES 2'h2

`endif

// ==== logic/nco_top.v ====
// Numerically controlled oscillator with byte register port.
// Clock-source inputs are levels synchronous to clk_sys; their rising
// edges, detected here, form the accumulator enable.
`timescale 1ns/1ns
`include "nco_defs.vh"

module nco_top (
   // System
   input wire clk_sys,
   input wire sys_rst,
   // Register port
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata_r,
   // Clock sources
   input wire fast_osc_clk,
   input wire sys_osc_clk,
   input wire logic_cell_one_output,
   // Results
   output reg osc_out_r,
   output reg osc_pin_out_r,
   output reg osc_pin_oe_r,
   output reg irq_req_r,
   output reg keep_fast_osc_r
);

   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   reg osc_enable_r;
   reg output_invert_r;
   reg output_divider_mode_r;
   reg [2:0] pulse_width_select_r;
   reg [1:0] input_clock_select_r;
   reg [19:0] acc_r;
   reg [19:0] inc_r;
   reg [19:0] increment_buffer_r;
   reg overflow_irq_flag_r;
   reg overflow_irq_enable_r;
   reg peripheral_irq_enable_r;
   reg global_irq_enable_r;
   reg pin_enable_r;
   reg clk_prev_r;
   reg load_armed_r;
   reg [1:0] load_cnt_r;
   reg carry_pend_r;
   reg toggle_r;
   reg pulse_active_r;
   reg [6:0] pulse_cnt_r;
   reg out_level_r;
   reg carry_seen_r;
   reg osc_output_level_r;
   reg inc_copy_r;

   reg clk_sel;
   reg [7:0] rd_nxt;
   wire [20:0] sum;
   wire clk_edge;
   wire tick;
   wire carry;
   wire raw_out;
   wire out_nxt;
   wire wr_ctrl;
   wire wr_clk;
   wire wr_irq;
   wire wr_incl;
   wire wr_inc_any;
   wire pol_changed;

   // Pulse length minus one, two to the field value periods
   function [6:0] width_m1;
      input [2:0] sel;
      begin
         width_m1 = (7'h01 << sel) - 7'h01;
      end
   endfunction

   // -------------------------------------------------------------------
   // Clock source and adder
   // -------------------------------------------------------------------
   always @* begin
      case (input_clock_select_r) // RQ4 RQ5
         `NCO_CKS_FAST: clk_sel = fast_osc_clk;
         `NCO_CKS_SYS: clk_sel = sys_osc_clk;
         `NCO_CKS_CELL: clk_sel = logic_cell_one_output;
         default: clk_sel = 1'b0;
      endcase
   end

   assign clk_edge = clk_sel & ~clk_prev_r;
   assign tick = clk_edge & osc_enable_r; // RQ26 RQ23
   assign sum = {1'b0, acc_r} + {1'b0, increment_buffer_r}; // RQ2
   assign carry = tick & sum[20]; // RQ3

   assign wr_ctrl = reg_wr && (reg_addr == `NCO_OFS_CTRL);
   assign wr_clk = reg_wr && (reg_addr == `NCO_OFS_CLK);
   assign wr_irq = reg_wr && (reg_addr == `NCO_OFS_IRQ);
   assign wr_incl = reg_wr && (reg_addr == `NCO_OFS_INCL);
   assign wr_inc_any = wr_incl || (reg_wr &&
      ((reg_addr == `NCO_OFS_INCH) || (reg_addr == `NCO_OFS_INCU)));
   assign pol_changed = wr_ctrl &&
      (reg_wdata[`NCO_CTRL_POL] != output_invert_r);

   // Output shaping
   assign raw_out = output_divider_mode_r ? pulse_active_r : toggle_r; // RQ11
   assign out_nxt = raw_out ^ output_invert_r; // RQ16

   // -------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (sys_rst) begin // RQ22
         osc_enable_r <= 1'b0;
         output_invert_r <= 1'b0;
         output_divider_mode_r <= 1'b0;
         pulse_width_select_r <= 3'h0;
         input_clock_select_r <= 2'h0;
         acc_r <= `NCO_ZERO20;
         inc_r <= `NCO_ZERO20;
         increment_buffer_r <= `NCO_ZERO20;
         overflow_irq_flag_r <= 1'b0;
         overflow_irq_enable_r <= 1'b0;
         peripheral_irq_enable_r <= 1'b0;
         global_irq_enable_r <= 1'b0;
         pin_enable_r <= 1'b0;
         clk_prev_r <= 1'b0;
         load_armed_r <= 1'b0;
         load_cnt_r <= 2'h0;
         carry_pend_r <= 1'b0;
         toggle_r <= 1'b0;
         pulse_active_r <= 1'b0;
         pulse_cnt_r <= 7'h00;
         out_level_r <= 1'b0;
         carry_seen_r <= 1'b0;
         osc_output_level_r <= 1'b0;
         inc_copy_r <= 1'b0;
      end else begin
         clk_prev_r <= clk_sel;
         inc_copy_r <= wr_inc_any;
         if (wr_ctrl) begin
            osc_enable_r <= reg_wdata[`NCO_CTRL_EN];
            output_invert_r <= reg_wdata[`NCO_CTRL_POL];
            output_divider_mode_r <= reg_wdata[`NCO_CTRL_PFM];
         end
         if (wr_clk) begin
            pulse_width_select_r <=
               reg_wdata[`NCO_CLK_PWS_HI:`NCO_CLK_PWS_LO]; // RQ13
            input_clock_select_r <=
               reg_wdata[`NCO_CLK_CKS_HI:`NCO_CLK_CKS_LO];
         end
         if (wr_irq) begin
            overflow_irq_enable_r <= reg_wdata[`NCO_IRQ_IE];
            peripheral_irq_enable_r <= reg_wdata[`NCO_IRQ_PERIPHERAL_IRQ_ENABLE];
            global_irq_enable_r <= reg_wdata[`NCO_IRQ_GIE];
            pin_enable_r <= reg_wdata[`NCO_IRQ_PIN];
         end

         // Increment bytes
         if (reg_wr && reg_addr == `NCO_OFS_INCL)
            inc_r[7:0] <= reg_wdata; // RQ6
         if (reg_wr && reg_addr == `NCO_OFS_INCH)
            inc_r[15:8] <= reg_wdata;
         if (reg_wr && reg_addr == `NCO_OFS_INCU)
            inc_r[19:16] <= reg_wdata[3:0];

         // Buffer loading
         if (!osc_enable_r) begin
            load_armed_r <= 1'b0;
            load_cnt_r <= 2'h0;
            if (wr_inc_any)
               increment_buffer_r <= inc_r; // RQ9
            else
               increment_buffer_r <= increment_buffer_r;
         end else if (wr_incl) begin
            load_armed_r <= 1'b1; // RQ8
            load_cnt_r <= 2'h0;
         end else if (load_armed_r && clk_edge) begin
            if (load_cnt_r + 2'h1 == `NCO_LOAD_EDGES) begin
               increment_buffer_r <= inc_r; // RQ8
               load_armed_r <= 1'b0;
               load_cnt_r <= 2'h0;
            end else begin
               load_cnt_r <= load_cnt_r + 2'h1;
            end
         end
         // Disabled copy follows the write by one cycle, once bytes settle
         if (!osc_enable_r && inc_copy_r)
            increment_buffer_r <= inc_r; // RQ9

         // Accumulator
         if (reg_wr && reg_addr == `NCO_OFS_ACCL)
            acc_r[7:0] <= reg_wdata; // RQ1
         else if (reg_wr && reg_addr == `NCO_OFS_ACCH)
            acc_r[15:8] <= reg_wdata;
         else if (reg_wr && reg_addr == `NCO_OFS_ACCU)
            acc_r[19:16] <= reg_wdata[3:0];
         else if (tick)
            acc_r <= sum[19:0]; // RQ2

         // Output generation on input clock edges
         if (tick) begin
            carry_pend_r <= sum[20];
            if (sum[20])
               toggle_r <= ~toggle_r; // RQ10
            if (carry_pend_r) begin
               pulse_active_r <= 1'b1; // RQ12 RQ15
               pulse_cnt_r <= width_m1(pulse_width_select_r); // RQ14
            end else if (pulse_active_r) begin
               if (pulse_cnt_r == 7'h00)
                  pulse_active_r <= 1'b0; // RQ12
               else
                  pulse_cnt_r <= pulse_cnt_r - 7'h01;
            end
         end
         if (!osc_enable_r) begin
            carry_pend_r <= 1'b0;
            pulse_active_r <= 1'b0;
         end

         // System-side staging
         out_level_r <= out_nxt; // RQ27
         carry_seen_r <= carry; // RQ27
         osc_output_level_r <= out_level_r; // RQ18

         // Flag: set wins over software clear
         if (carry_seen_r ||
             (pol_changed && overflow_irq_enable_r)) // RQ20 RQ17
            overflow_irq_flag_r <= 1'b1;
         else if (wr_irq && !reg_wdata[`NCO_IRQ_FLAG])
            overflow_irq_flag_r <= 1'b0; // RQ21
      end
   end

   // -------------------------------------------------------------------
   // Read port and outputs
   // -------------------------------------------------------------------
   always @* begin
      rd_nxt = `NCO_ZERO8;
      case (reg_addr)
         `NCO_OFS_CTRL: rd_nxt = {osc_enable_r, 1'b0, osc_output_level_r,
            output_invert_r, 3'h0, output_divider_mode_r};
         `NCO_OFS_CLK: rd_nxt = {pulse_width_select_r, 3'h0,
            input_clock_select_r};
         `NCO_OFS_ACCL: rd_nxt = acc_r[7:0]; // RQ25
         `NCO_OFS_ACCH: rd_nxt = acc_r[15:8];
         `NCO_OFS_ACCU: rd_nxt = {4'h0, acc_r[19:16]};
         `NCO_OFS_INCL: rd_nxt = inc_r[7:0];
         `NCO_OFS_INCH: rd_nxt = inc_r[15:8];
         `NCO_OFS_INCU: rd_nxt = {4'h0, inc_r[19:16]};
         `NCO_OFS_IRQ: rd_nxt = {3'h0, pin_enable_r, global_irq_enable_r,
            peripheral_irq_enable_r, overflow_irq_enable_r,
            overflow_irq_flag_r};
         default: rd_nxt = `NCO_ZERO8;
      endcase
   end

   always @(posedge clk_sys) begin
      if (sys_rst) begin
         reg_rdata_r <= `NCO_ZERO8;
         osc_out_r <= 1'b0;
         osc_pin_out_r <= 1'b0;
         osc_pin_oe_r <= 1'b0;
         irq_req_r <= 1'b0;
         keep_fast_osc_r <= 1'b0;
      end else begin
         reg_rdata_r <= reg_rd ? rd_nxt : `NCO_ZERO8;
         osc_out_r <= out_nxt; // RQ19
         osc_pin_out_r <= out_nxt & pin_enable_r; // RQ19
         osc_pin_oe_r <= pin_enable_r;
         irq_req_r <= overflow_irq_flag_r & osc_enable_r &
            overflow_irq_enable_r & peripheral_irq_enable_r &
            global_irq_enable_r; // RQ20
         keep_fast_osc_r <= osc_enable_r &&
            (input_clock_select_r == `NCO_CKS_FAST); // RQ24
      end
   end

endmodule

// ==== tb/nco_checker_assertions.sv ====
// Port-level checker for the oscillator block, bound to nco_top.
// Assumes registers change only through the byte port.
`timescale 1ns/1ns
`include "nco_defs.vh"
module nco_checker (
   // System
   input wire clk_sys,
   input wire sys_rst,
   // Register port
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_rdata_r,
   // Clock sources
   input wire fast_osc_clk,
   input wire sys_osc_clk,
   input wire logic_cell_one_output,
   // Results
   input wire osc_out_r,
   input wire osc_pin_out_r,
   input wire osc_pin_oe_r,
   input wire irq_req_r,
   input wire keep_fast_osc_r
);
   reg [7:0] ctl_r;
   reg [7:0] irq_r;
   reg [1:0] sel_r;
   wire all_on = ctl_r[7] && (irq_r[3:1] == 3'h7);
   // ----------------------------------------------------------------
   // Shadow of written control bits
   // ----------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         ctl_r <= 8'h00;
         irq_r <= 8'h00;
         sel_r <= 2'h0;
      end else if (reg_wr) begin
         if (reg_addr == `NCO_OFS_CTRL) ctl_r <= reg_wdata;
         if (reg_addr == `NCO_OFS_CLK) sel_r <= reg_wdata[1:0];
         if (reg_addr == `NCO_OFS_IRQ) irq_r <= reg_wdata;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   a_read_idle: assert property (
      !$past(reg_rd) |-> reg_rdata_r == 8'h00)
      else $error("read data outside its slot");
   a_hidden_addr: assert property (
      reg_rd && reg_addr > `NCO_OFS_IRQ |=> reg_rdata_r == 8'h00)
      else $error("unmapped index read nonzero");
   a_upper_nibble: assert property (
      reg_rd && (reg_addr == `NCO_OFS_ACCU || reg_addr == `NCO_OFS_INCU)
      |=> reg_rdata_r[7:4] == 4'h0)
      else $error("upper byte high nibble nonzero");
   a_pin_gate: assert property (osc_pin_out_r |-> osc_pin_oe_r)
      else $error("pin data without enable");
   a_pin_follow: assert property (
      osc_pin_oe_r && $past(osc_pin_oe_r) && $stable(osc_out_r)
      |-> osc_pin_out_r == osc_out_r)
      else $error("pin does not follow output");
   a_fast_keep: assert property (
      ctl_r[7] == $past(ctl_r[7]) && sel_r == $past(sel_r)
      |-> keep_fast_osc_r == (ctl_r[7] && sel_r == `NCO_CKS_FAST))
      else $error("fast oscillator keep wrong");
   a_irq_gate: assert property (irq_req_r |-> all_on || $past(all_on))
      else $error("request without all enables");
   a_pol_irq: assert property (
      reg_wr && reg_addr == `NCO_OFS_CTRL && reg_wdata[7] && all_on
      && reg_wdata[4] != ctl_r[4] |-> ##[1:4] irq_req_r)
      else $error("polarity change gave no request");
   a_frozen_out: assert property (
      !ctl_r[7] && ctl_r == $past(ctl_r, 4) |-> $stable(osc_out_r))
      else $error("output moved while disabled");
   c_enable: cover property (reg_wr && reg_addr == `NCO_OFS_CTRL && reg_wdata[7]);
   c_irq: cover property ($rose(irq_req_r));
   c_pin: cover property ($rose(osc_pin_out_r));
endmodule
bind nco_top nco_checker u_chk (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata_r(reg_rdata_r), .fast_osc_clk(fast_osc_clk),
   .sys_osc_clk(sys_osc_clk), .logic_cell_one_output(logic_cell_one_output),
   .osc_out_r(osc_out_r), .osc_pin_out_r(osc_pin_out_r),
   .osc_pin_oe_r(osc_pin_oe_r), .irq_req_r(irq_req_r),
   .keep_fast_osc_r(keep_fast_osc_r)
);

// ==== tb/nco_src_model.sv ====
// Model of the three selectable input clocks.
// Assumes levels stepped on clk_sys; only the chosen one toggles.
`timescale 1ns/1ns
module nco_src_model (
   // System
   input wire clk_sys,
   // Control
   input wire [1:0] which,
   input wire run,
   // Sources and rising-edge count
   output wire [2:0] src,
   output reg [15:0] edges
);
   reg ph = 1'b0;
   reg cnt = 1'b0;
   // Idle low between bursts; code 11 drives no source
   assign src = ph ? (3'h1 << which) : 3'h0;
   always @(posedge clk_sys) begin
      if (!run) begin
         ph <= 1'b0;
         cnt <= 1'b0;
         edges <= 16'h0000;
      end else begin
         cnt <= ~cnt;
         if (cnt) begin
            ph <= ~ph;
            if (!ph) edges <= edges + 16'h0001;
         end
      end
   end
endmodule

// ==== tb/nco_tb_top.sv ====
// Self-checking bench for the oscillator block.
// Assumes a 10 MHz clk_sys and sources from nco_src_model.
`timescale 1ns/1ns
`include "nco_defs.vh"
module nco_tb_top;
   reg clk_sys, sys_rst, reg_wr, reg_rd, run, clr, prv, irq_seen;
   reg [3:0] reg_addr;
   reg [7:0] reg_wdata, rv;
   reg [1:0] which;
   reg [19:0] av;
   reg [39:0] prod;
   wire [7:0] reg_rdata_r;
   wire [2:0] src;
   wire [15:0] edges;
   wire osc_out_r, osc_pin_out_r, osc_pin_oe_r, irq_req_r, keep_fast_osc_r;
   integer bad_count = 0;
   integer check_count = 0;
   integer chg, ups, hi, i, t;
   nco_top i_dut (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata_r(reg_rdata_r), .fast_osc_clk(src[0]),
      .sys_osc_clk(src[1]), .logic_cell_one_output(src[2]),
      .osc_out_r(osc_out_r), .osc_pin_out_r(osc_pin_out_r),
      .osc_pin_oe_r(osc_pin_oe_r), .irq_req_r(irq_req_r),
      .keep_fast_osc_r(keep_fast_osc_r)
   );
   nco_src_model i_src (.clk_sys(clk_sys), .which(which), .run(run),
      .src(src), .edges(edges));
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   // Output change, rise and high-time counters
   always @(posedge clk_sys) begin
      prv <= osc_out_r;
      if (clr) begin
         chg <= 0;
         ups <= 0;
         hi <= 0;
      end else begin
         if (osc_out_r !== prv) chg <= chg + 1;
         if (osc_out_r && !prv) ups <= ups + 1;
         if (osc_out_r) hi <= hi + 1;
      end
   end
   task print_verdict;
      begin
         if (bad_count == 0 && check_count > 0) begin
            $display("verification passed");
         end else begin
            $display("verification failed");
         end
         $finish;
      end
   endtask
   task chk(input [19:0] got, input [19:0] exp);
      begin
         check_count = check_count + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task wr(input [3:0] a, input [7:0] d);
      begin
         reg_addr <= a;
         reg_wdata <= d;
         reg_wr <= 1'b1;
         @(posedge clk_sys);
         reg_wr <= 1'b0;
         @(posedge clk_sys);
      end
   endtask
   task rd(input [3:0] a);
      begin
         reg_addr <= a;
         reg_rd <= 1'b1;
         @(posedge clk_sys);
         reg_rd <= 1'b0;
         #1;
         rv = reg_rdata_r;
         @(posedge clk_sys);
      end
   endtask
   task rdacc(input [19:0] e);
      begin
         rd(`NCO_OFS_ACCL);
         av[7:0] = rv;
         rd(`NCO_OFS_ACCH);
         av[15:8] = rv;
         rd(`NCO_OFS_ACCU);
         av[19:16] = rv[3:0];
         chk(av, e);
      end
   endtask
   task setinc(input [19:0] v);
      begin
         wr(`NCO_OFS_INCU, {4'h0, v[19:16]});
         wr(`NCO_OFS_INCH, v[15:8]);
         wr(`NCO_OFS_INCL, v[7:0]);
      end
   endtask
   task go(input [15:0] n);
      begin
         run <= 1'b1;
         t = 0;
         while (edges !== n && t < 2000) begin
            @(posedge clk_sys);
            t = t + 1;
         end
         run <= 1'b0;
         if (t >= 2000) begin
            bad_count = bad_count + 1;
            print_verdict;
         end else begin
            repeat (8) @(posedge clk_sys);
            irq_seen = irq_req_r;
         end
      end
   endtask
   task run_case(input [1:0] sel, input [7:0] ctl, input [2:0] w,
      input [19:0] inc, input [15:0] n);
      begin
         which <= sel;
         wr(`NCO_OFS_CTRL, ctl & 8'h7F);
         wr(`NCO_OFS_CLK, {w, 3'h0, sel});
         setinc(inc);
         wr(`NCO_OFS_ACCL, 8'h00);
         wr(`NCO_OFS_ACCH, 8'h00);
         wr(`NCO_OFS_ACCU, 8'h00);
         clr <= 1'b1;
         wr(`NCO_OFS_CTRL, ctl);
         clr <= 1'b0;
         go(n);
         wr(`NCO_OFS_CTRL, ctl & 8'h7F);
         prod = n * inc;
         if (!ctl[7] || sel == 2'h3) prod = 40'h0;
         rdacc(prod[19:0]);
      end
   endtask
   initial begin
      sys_rst = 1'b1;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      which = 2'h0;
      run = 1'b0;
      clr = 1'b1;
      repeat (12) @(posedge clk_sys);
      sys_rst <= 1'b0;
      for (i = 0; i < 10; i = i + 1) begin
         rd(i[3:0]);
         chk(rv, 20'h00000);
      end
      wr(`NCO_OFS_INCU, 8'hFF);
      rd(`NCO_OFS_INCU);
      chk(rv, 20'h0000F);
      wr(`NCO_OFS_CLK, 8'hFF);
      rd(`NCO_OFS_CLK);
      chk(rv, 20'h000E3);
      wr(`NCO_OFS_CTRL, 8'h11);
      repeat (3) @(posedge clk_sys);
      rd(`NCO_OFS_CTRL);
      chk(rv, 20'h00031);
      for (i = 0; i < 4; i = i + 1) begin
         run_case(i[1:0], 8'h80, 3'h0, 20'h6AAAB + i, 16'h000C);
         chk(chg, prod[39:20]);
      end
      run_case(2'h1, 8'h00, 3'h0, 20'h12345, 16'h0008);
      setinc(20'h00000);
      wr(`NCO_OFS_CTRL, 8'h80);
      setinc(20'h10000);
      go(16'h000A);
      wr(`NCO_OFS_CTRL, 8'h00);
      rdacc(20'h80000);
      run_case(2'h0, 8'h81, 3'h0, 20'h80000, 16'h0014);
      chk(ups, 9);
      chk(hi, 36);
      run_case(2'h1, 8'h81, 3'h2, 20'h10000, 16'h0046);
      chk(ups, 4);
      chk(hi, 64);
      run_case(2'h2, 8'h81, 3'h7, 20'h80000, 16'h0028);
      chk(ups, 1);
      wr(`NCO_OFS_IRQ, 8'h1E);
      run_case(2'h2, 8'h80, 3'h0, 20'h80000, 16'h0004);
      chk(irq_seen, 1);
      chk(osc_pin_oe_r, 1);
      rd(`NCO_OFS_IRQ);
      chk(rv, 20'h0001F);
      wr(`NCO_OFS_IRQ, 8'h17);
      rd(`NCO_OFS_IRQ);
      chk(rv, 20'h00017);
      wr(`NCO_OFS_IRQ, 8'h1E);
      rd(`NCO_OFS_IRQ);
      chk(rv, 20'h0001E);
      wr(`NCO_OFS_CTRL, 8'h81);
      wr(`NCO_OFS_CTRL, 8'h91);
      repeat (4) @(posedge clk_sys);
      chk(irq_req_r, 1);
      chk(osc_out_r, 1);
      rd(`NCO_OFS_CTRL);
      chk(rv, 20'h000B1);
      print_verdict;
   end
endmodule
